// [tb/mrx_exec_sva.sv]
module mrx_exec_sva
    import mrx_pkg::*;
(
    input wire logic                clk,
    input wire logic                rst,
    input wire logic [3:0]          bus_addr,
    input wire logic [7:0]          bus_wdata,
    input wire logic                bus_wr,
    input wire logic [7:0]          mem_rdata,
    input wire mrx_pkg::mrx_mem_req_t mem_req,
    input wire mrx_pkg::mrx_seq_t   seq,
    input wire logic                pc_advance,
    input wire logic                global_irq_enable
);
    timeunit 1ns;
    timeprecision 1ps;
    // ==========================================
    // helpers
    logic [7:0] mem_q;
    logic       go;
    logic [4:0] opc;
    assign go  = bus_wr && bus_addr == REG_OPCODE;
    assign opc = bus_wdata[4:0];
    always_ff @(posedge clk) begin
        mem_q <= mem_rdata;
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    // ==========================================
    // properties
    AST_NOP: assert property (go && opc == nop_op |-> ##2 pc_advance && !mem_req.wr && !seq.pop)
        else $error("nop did more than advance");
    AST_MOVM: assert property (go && opc == mov_mem_from_acc_op |-> ##2 mem_req.wr)
        else $error("store did not write memory");
    AST_RET: assert property (go && opc == return_op |-> ##2 seq.pop && !pc_advance ##1 seq.dummy)
        else $error("return not two cycles with pop");
    AST_INTERRUPT_RETURN_OP: assert property (go && opc == interrupt_return_op |-> ##2 global_irq_enable)
        else $error("interrupt return left irq disabled");
    AST_RL: assert property (go && opc == rotate_left_op |->
        ##2 mem_req.wr && mem_req.wdata == {mem_q[6:0], mem_q[7]})
        else $error("rotate left wrong");
    AST_RR: assert property (go && opc == rotate_right_op |->
        ##2 mem_req.wr && mem_req.wdata == {mem_q[0], mem_q[7:1]})
        else $error("rotate right wrong");
    AST_ACC_DEST: assert property (go && opc inside {
        rotate_left_to_acc_op, rotate_right_to_acc_op, rotate_left_carry_to_acc_op, rotate_right_carry_to_acc_op}
        |-> ##2 !mem_req.wr)
        else $error("accumulator rotate wrote memory");
    AST_SKIP: assert property (go
        && opc inside {decrement_skip_zero_op, decrement_skip_zero_to_acc_op}
        ##1 mem_rdata == 8'h01 |=> seq.skip ##1 seq.dummy)
        else $error("zero decrement did not skip");
    AST_NOSKIP: assert property (go && opc == decrement_skip_zero_op
        ##1 mem_rdata != 8'h01 |=> !seq.skip && mem_req.wdata == mem_q - 8'h01 ##1 !seq.dummy)
        else $error("nonzero decrement skipped");
    AST_RETV: assert property (go && opc == return_value_op |-> ##2 seq.pop && !pc_advance ##1 seq.dummy)
        else $error("value return not two cycles with pop");
    AST_SBC: assert property (go && opc == subtract_borrow_op |->
        ##2 pc_advance && !mem_req.wr && !seq.skip)
        else $error("subtract with borrow wrote memory or skipped");
    AST_SUBTRACT_BORROW_TO_MEM_OP: assert property (go && opc == subtract_borrow_to_mem_op |->
        ##2 pc_advance && mem_req.wr && !seq.skip)
        else $error("subtract with borrow to memory did not write");
endmodule : mrx_exec_sva

// [tb/mrx_exec_tb.sv]
module mrx_exec_tb
    import mrx_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic         clk = 1'b0, rst = 1'b1, bus_wr = 1'b0, bus_rd = 1'b0, pc_advance, global_irq_enable;
    logic [3:0]   bus_addr = 4'h0;
    logic [7:0]   bus_wdata = 8'h00, bus_rdata, mem_rdata, r, acc, m, e_mem;
    logic [7:0]   mem [512];
    logic [8:0]   cur_addr = 9'h000, s, a;
    logic [3:0]   fl;
    logic         irq = 1'b0, skp;
    mrx_mem_req_t mem_req;
    mrx_seq_t     seq;
    int           fail_count = 0, checks = 0, op;
    always #12.5 clk = ~clk;
    // memory answers at the latched operand address
    assign mem_rdata = mem[cur_addr];
    always @(posedge clk) if (mem_req.wr) mem[mem_req.addr] <= mem_req.wdata;
    mrx_exec mrx_exec_inst (.clk(clk), .rst(rst), .bus_addr(bus_addr), .bus_wdata(bus_wdata),
        .bus_wr(bus_wr), .bus_rd(bus_rd), .bus_rdata(bus_rdata), .mem_rdata(mem_rdata),
        .mem_req(mem_req), .seq(seq), .pc_advance(pc_advance), .global_irq_enable(global_irq_enable));
    // ==========================================
    // bus and report tasks
    task automatic wr(input logic [3:0] ad, input logic [7:0] d);
        @(posedge clk);
        bus_addr <= ad;
        bus_wdata <= d;
        bus_wr <= 1'b1;
        @(posedge clk);
        bus_wr <= 1'b0;
    endtask : wr
    task automatic rd(input logic [3:0] ad, output logic [7:0] d);
        @(posedge clk);
        bus_addr <= ad;
        bus_rd <= 1'b1;
        @(posedge clk);
        bus_rd <= 1'b0;
        #1;
        d = bus_rdata;
    endtask : rd
    task automatic chk(input logic [7:0] g, input logic [7:0] e);
        checks++;
        if (g !== e) begin
            $display("CHECK FAILED at %0t: got %h expected %h", $time, g, e);
            fail_count++;
        end
    endtask : chk
    task automatic end_of_test;
        $display("mismatches %0d of %0d checks", fail_count, checks);
        if (fail_count == 0 && checks > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask : end_of_test
    initial begin
        #500us;
        fail_count++;
        end_of_test();
    end
    // ==========================================
    // every op first, then random ops on random state
    initial begin
        void'($urandom(32'h6b2879e7));
        for (int i = 0; i < 512; i++) mem[i] = 8'($urandom);
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        rd(REG_ACC, r);
        chk(r, ACC_RST);
        rd(4'hf, r);
        chk(r, 8'h00);
        for (int i = 0; i < 300; i++) begin
            op = (i < 22) ? i : int'($urandom % 22);
            a = 9'($urandom);
            acc = 8'($urandom);
            fl = 4'($urandom);
            // half the time force the decrement-to-zero boundary
            if ($urandom % 2) mem[a] = 8'h01;
            m = mem[a];
            wr(REG_ACC, acc);
            wr(REG_FLAGS, {4'h0, fl});
            wr(REG_OPER, a[7:0]);
            wr(REG_ADDRHI, {7'h00, a[8]});
            cur_addr <= a;
            wr(REG_OPCODE, 8'(op));
            e_mem = m;
            s = 9'h000;
            case (op)
                1: acc = m;
                2, 8: acc = a[7:0];
                3: e_mem = acc;
                4: acc = acc | m;
                5: acc = acc | a[7:0];
                6: e_mem = acc | m;
                9: irq = 1'b1;
                10: e_mem = {m[6:0], m[7]};
                11: acc = {m[6:0], m[7]};
                12, 13: s = {m, fl[0]};
                14: e_mem = {m[0], m[7:1]};
                15: acc = {m[0], m[7:1]};
                16, 17: s = {m[0], fl[0], m[7:1]};
                18, 19: begin
                    s = {1'b0, acc} + {1'b0, ~m} + 9'(fl[0]);
                    fl[1] = ({1'b0, acc[3:0]} + {1'b0, ~m[3:0]} + {4'h0, fl[0]}) > 5'd15;
                    fl[3] = (acc[7] == ~m[7]) && (s[7] != acc[7]);
                    fl[2] = s[7:0] == 8'h00;
                end
                20, 21: s = {1'b0, m - 8'h01};
                default: ;
            endcase
            if (op inside {12, 13, 16, 17, 18, 19}) fl[0] = s[8];
            if (op inside {4, 5, 6}) fl[2] = ((op == 6) ? e_mem : acc) == 8'h00;
            if (op inside {13, 17, 18, 21}) acc = s[7:0];
            if (op inside {12, 16, 19, 20}) e_mem = s[7:0];
            skp = (op inside {20, 21}) && (s[7:0] == 8'h00);
            repeat (3) @(posedge clk);
            rd(REG_ACC, r);
            chk(r, acc);
            rd(REG_FLAGS, r);
            chk({4'h0, r[3:0]}, {4'h0, fl});
            rd(REG_STATUS, r);
            chk({6'h00, r[2], global_irq_enable}, {6'h00, irq, irq});
            chk({6'h00, r[1:0]}, {6'h00, skp, 1'b0});
            chk(mem[a], e_mem);
        end
        end_of_test();
    end
endmodule : mrx_exec_tb
bind mrx_exec mrx_exec_sva mrx_exec_sva_inst (.clk(clk), .rst(rst), .bus_addr(bus_addr),
    .bus_wdata(bus_wdata), .bus_wr(bus_wr), .mem_rdata(mem_rdata), .mem_req(mem_req), .seq(seq),
    .pc_advance(pc_advance), .global_irq_enable(global_irq_enable));

// [verilog/mrx_alu.sv]
module mrx_alu
    import mrx_pkg::*;
(
    input  wire mrx_pkg::mrx_op_t    op,
    input  wire logic [7:0]          acc,
    input  wire logic [7:0]          mem,
    input  wire logic [7:0]          imm,
    input  wire mrx_pkg::mrx_flags_t flags_in,
    output mrx_pkg::mrx_flags_t      flags_out,
    output logic [7:0]               result
);
    logic [8:0] sum;
    logic [4:0] low;
    logic [7:0] mem_n;

    always_comb begin
        mem_n     = ~mem;
        sum       = {1'b0, acc} + {1'b0, mem_n} + {8'h00, flags_in.carry_flag};
        low       = {1'b0, acc[3:0]} + {1'b0, mem_n[3:0]} + {4'h0, flags_in.carry_flag};
        flags_out = flags_in; // RULE21
        result    = acc;
        case (op)
            mov_acc_from_mem_op:  result = mem; // RULE1
            mov_acc_imm_op:       result = imm; // RULE2
            return_value_op:      result = imm; // RULE8
            mov_mem_from_acc_op:  result = acc; // RULE3
            or_mem_op: begin
                result              = acc | mem; // RULE5
                flags_out.zero_flag = (result == 8'h00); // RULE22
            end
            or_imm_op: begin
                result              = acc | imm; // RULE5
                flags_out.zero_flag = (result == 8'h00); // RULE22
            end
            or_to_memory_op: begin
                result              = acc | mem; // RULE6
                flags_out.zero_flag = (result == 8'h00); // RULE22
            end
            rotate_left_op, rotate_left_to_acc_op:   result = {mem[6:0], mem[7]}; // RULE10 RULE11
            rotate_right_op, rotate_right_to_acc_op: result = {mem[0], mem[7:1]}; // RULE12 RULE13
            rotate_left_carry_op, rotate_left_carry_to_acc_op: begin
                result               = {mem[6:0], flags_in.carry_flag}; // RULE14
                flags_out.carry_flag = mem[7]; // RULE14
            end
            rotate_right_carry_op, rotate_right_carry_to_acc_op: begin
                result               = {flags_in.carry_flag, mem[7:1]}; // RULE15
                flags_out.carry_flag = mem[0]; // RULE15
            end
            subtract_borrow_op, subtract_borrow_to_mem_op: begin
                result                   = sum[7:0]; // RULE16 RULE17
                flags_out.carry_flag     = sum[8];
                flags_out.aux_carry_flag = low[4];
                flags_out.zero_flag      = (sum[7:0] == 8'h00); // RULE22
                // signed overflow: operands agree in sign, result differs
                flags_out.overflow_flag  = (acc[7] == mem_n[7]) && (sum[7] != acc[7]);
            end
            decrement_skip_zero_op, decrement_skip_zero_to_acc_op:
                result = mem - 8'h01; // RULE18 RULE20
            default: result = acc; // RULE4
        endcase
    end
endmodule : mrx_alu

// [verilog/mrx_exec.sv]
// Functional notes
// RULE1: load accumulator from memory, flags kept
// RULE2: load accumulator with 8-bit immediate
// RULE3: store accumulator into memory byte
// RULE4: no-operation only advances program counter
// RULE5: OR into accumulator, zero flag only
// RULE6: OR written back to memory, zero only
// RULE7: return pops stack, two cycles
// RULE8: return loads accumulator with immediate
// RULE9: interrupt return sets global enable
// RULE10: rotate memory left, bit7 to bit0
// RULE11: rotate left into accumulator, memory kept
// RULE12: rotate memory right, bit0 to bit7
// RULE13: rotate right into accumulator, memory kept
// RULE14: left rotate through carry, carry only
// RULE15: right rotate through carry, carry only
// RULE16: subtract with borrow into accumulator
// RULE17: subtract with borrow into memory
// RULE18: decrement memory, no flags change
// RULE19: zero result skips with dummy cycle
// RULE20: decrement into accumulator, skip on zero
// RULE21: unlisted flags keep their value
// RULE22: zero flag set on zero result
//
// The address-and-strobe port and the register addresses were decided locally.
module mrx_exec
    import mrx_pkg::*;
(
    input  wire logic                clk,
    input  wire logic                rst,
    input  wire logic [3:0]          bus_addr,
    input  wire logic [7:0]          bus_wdata,
    input  wire logic                bus_wr,
    input  wire logic                bus_rd,
    output logic [7:0]               bus_rdata,
    input  wire logic [7:0]          mem_rdata,
    output mrx_pkg::mrx_mem_req_t    mem_req,
    output mrx_pkg::mrx_seq_t        seq,
    output logic                     pc_advance,
    output logic                     global_irq_enable
);
    import mrx_pkg::*;

    // ==========================================================
    // state
    typedef enum logic [1:0] {
        st_idle,
        st_exec,
        st_second
    } mrx_phase_t;

    typedef struct packed {
        mrx_phase_t         phase;
        mrx_op_t            op;
        logic [ADDR_W-1:0]  addr;
        logic [7:0]         imm;
        logic [7:0]         acc;
        mrx_flags_t         flags;
        logic               irq_en;
        logic               skip_seen;
        logic [7:0]         rdata;
        mrx_mem_req_t       mem_req;
        mrx_seq_t           seq;
        logic               pc_adv;
    } mrx_state_t;

    mrx_state_t q;
    mrx_state_t next_q;
    mrx_flags_t alu_flags;
    logic [7:0] alu_result;

    mrx_alu u_alu (
        .op        (q.op),
        .acc       (q.acc),
        .mem       (mem_rdata),
        .imm       (q.imm),
        .flags_in  (q.flags),
        .flags_out (alu_flags),
        .result    (alu_result)
    );

    // ==========================================================
    // next state
    always_comb begin
        next_q          = q;
        next_q.mem_req  = '0;
        next_q.seq      = '0;
        next_q.pc_adv   = 1'b0;
        next_q.rdata    = 8'h00;

        if (bus_rd) begin
            case (bus_addr)
                REG_ACC:    next_q.rdata = q.acc;
                REG_FLAGS:  next_q.rdata = {4'h0, q.flags};
                REG_STATUS: next_q.rdata = {5'h00, q.irq_en, q.skip_seen, q.phase != st_idle};
                default:    next_q.rdata = 8'h00;
            endcase
        end

        case (q.phase)
            st_idle: begin
                if (bus_wr) begin
                    case (bus_addr)
                        REG_OPCODE: begin
                            next_q.op    = mrx_op_t'(bus_wdata[4:0]);
                            next_q.phase = st_exec;
                        end
                        REG_OPER: begin
                            next_q.addr[7:0] = bus_wdata;
                            next_q.imm       = bus_wdata;
                        end
                        REG_ADDRHI: next_q.addr[ADDR_W-1] = bus_wdata[0];
                        REG_ACC:    next_q.acc   = bus_wdata;
                        REG_FLAGS:  next_q.flags = mrx_flags_t'(bus_wdata[3:0]);
                        default:    next_q = next_q;
                    endcase
                end
            end
            st_exec: begin
                // memory byte is read combinationally at q.addr this cycle
                next_q.flags  = alu_flags; // RULE21
                next_q.phase  = st_idle;
                next_q.pc_adv = 1'b1; // RULE4
                case (q.op)
                    mov_acc_from_mem_op, mov_acc_imm_op, or_mem_op, or_imm_op,
                    rotate_left_to_acc_op, rotate_right_to_acc_op,
                    rotate_left_carry_to_acc_op, rotate_right_carry_to_acc_op,
                    subtract_borrow_op:
                        next_q.acc = alu_result; // RULE1 RULE2 RULE5 RULE11 RULE13 RULE16
                    mov_mem_from_acc_op, or_to_memory_op, rotate_left_op, rotate_right_op,
                    rotate_left_carry_op, rotate_right_carry_op, subtract_borrow_to_mem_op: begin
                        next_q.mem_req = '{wr: 1'b1, addr: q.addr, wdata: alu_result}; // RULE3 RULE6 RULE10 RULE17
                    end
                    decrement_skip_zero_op: begin
                        next_q.mem_req = '{wr: 1'b1, addr: q.addr, wdata: alu_result}; // RULE18
                        if (alu_result == 8'h00) begin
                            next_q.seq.skip = 1'b1; // RULE19
                            next_q.phase    = st_second;
                        end
                    end
                    decrement_skip_zero_to_acc_op: begin
                        next_q.acc = alu_result; // RULE20
                        if (alu_result == 8'h00) begin
                            next_q.seq.skip = 1'b1; // RULE19
                            next_q.phase    = st_second;
                        end
                    end
                    return_op, interrupt_return_op, return_value_op: begin
                        next_q.pc_adv  = 1'b0;
                        next_q.seq.pop = 1'b1; // RULE7
                        next_q.phase   = st_second; // RULE7
                        if (q.op == return_value_op)
                            next_q.acc = alu_result; // RULE8
                        if (q.op == interrupt_return_op)
                            next_q.irq_en = 1'b1; // RULE9
                    end
                    default: next_q.acc = q.acc; // RULE4
                endcase
                next_q.skip_seen = next_q.seq.skip;
            end
            st_second: begin
                // prefetched word is thrown away; this slot is the dummy cycle
                next_q.seq.dummy = 1'b1; // RULE19
                next_q.phase     = st_idle;
            end
            default: next_q.phase = st_idle;
        endcase
    end

    // ==========================================================
    // registers
    always_ff @(posedge clk) begin
        if (rst) begin
            q        <= '0;
            q.phase  <= st_idle;
            q.op     <= nop_op;
            q.acc    <= ACC_RST;
            q.irq_en <= IRQEN_RST;
        end else begin
            q <= next_q;
        end
    end

    assign bus_rdata         = q.rdata;
    assign mem_req           = q.mem_req;
    assign seq               = q.seq;
    assign pc_advance        = q.pc_adv;
    assign global_irq_enable = q.irq_en;

endmodule : mrx_exec

// [verilog/mrx_pkg.sv]
package mrx_pkg;

    // ==========================================================
    // widths
    localparam int DATA_W = 8;
    localparam int ADDR_W = 9;
    localparam int PC_W   = 13;

    // ==========================================================
    // reset values
    localparam logic [7:0] ACC_RST   = 8'h00;
    localparam logic       FLAG_RST  = 1'b0;
    localparam logic       IRQEN_RST = 1'b0;

    // ==========================================================
    // register map of the plain command port
    localparam logic [3:0] REG_OPCODE = 4'h0; // write: opcode, starts execution
    localparam logic [3:0] REG_OPER   = 4'h1; // write: address low / immediate
    localparam logic [3:0] REG_ACC    = 4'h2; // read/write accumulator
    localparam logic [3:0] REG_FLAGS  = 4'h3; // read/write status flags
    localparam logic [3:0] REG_STATUS = 4'h4; // read: busy, skip, irq enable
    localparam logic [3:0] REG_ADDRHI = 4'h5; // write: address bit 8

    // flag field positions
    localparam int FLAG_CARRY     = 0;
    localparam int FLAG_AUX_CARRY = 1;
    localparam int FLAG_ZERO      = 2;
    localparam int FLAG_OVERFLOW  = 3;

    // ==========================================================
    // operation codes
    typedef enum logic [4:0] {
        nop_op,
        mov_acc_from_mem_op,
        mov_acc_imm_op,
        mov_mem_from_acc_op,
        or_mem_op,
        or_imm_op,
        or_to_memory_op,
        return_op,
        return_value_op,
        interrupt_return_op,
        rotate_left_op,
        rotate_left_to_acc_op,
        rotate_left_carry_op,
        rotate_left_carry_to_acc_op,
        rotate_right_op,
        rotate_right_to_acc_op,
        rotate_right_carry_op,
        rotate_right_carry_to_acc_op,
        subtract_borrow_op,
        subtract_borrow_to_mem_op,
        decrement_skip_zero_op,
        decrement_skip_zero_to_acc_op
    } mrx_op_t;

    typedef struct packed {
        logic overflow_flag;
        logic zero_flag;
        logic aux_carry_flag;
        logic carry_flag;
    } mrx_flags_t;

    typedef struct packed {
        logic              wr;
        logic [ADDR_W-1:0] addr;
        logic [7:0]        wdata;
    } mrx_mem_req_t;

    typedef struct packed {
        logic            pop;
        logic            skip;
        logic            dummy;
    } mrx_seq_t;

endpackage : mrx_pkg
